// ### core/ucs_regs.vh
// Register offsets, field positions and reset values for the USB control/config/status block
`ifndef UCS_REGS_VH
`define UCS_REGS_VH

// Byte addresses (word aligned)
`define UCS_ADDR_CONTROL 4'h0
`define UCS_ADDR_CONFIG 4'h4
`define UCS_ADDR_STATUS 4'h8
`define UCS_ADDR_TRN 4'hC

// Control fields
`define UCS_CTL_PP_RESET 6
`define UCS_CTL_SE0 5
`define UCS_CTL_FREEZE 4
`define UCS_CTL_ENABLE 3
`define UCS_CTL_RESUME 2
`define UCS_CTL_SUSPEND 1
`define UCS_CTL_RST 8'h00

// Configuration fields
`define UCS_CFG_EYE 7
`define UCS_CFG_PULLUP 4
`define UCS_CFG_FULL_SPEED 2
`define UCS_CFG_PPB_LO 0
`define UCS_CFG_WMASK 8'h97
`define UCS_CFG_RST 8'h00

// Buffer alternation encodings
`define UCS_PPB_NONE 2'b00
`define UCS_PPB_EP0_OUT 2'b01
`define UCS_PPB_ALL 2'b10
`define UCS_PPB_EP1_15 2'b11

// Transaction status entry and queue
`define UCS_STAT_EP_LO 3
`define UCS_STAT_DIR 2
`define UCS_STAT_ODD 1
`define UCS_STAT_MASK 8'h7E
`define UCS_STAT_RST 8'h00
`define UCS_QUEUE_DEPTH 4
`define UCS_TRN_DONE 0

`endif

// ### core/ucs_sync2.v
// Two-stage synchroniser for a single asynchronous level
`timescale 1ns/10ps
module ucs_sync2 (
  input wire core_clk,
  input wire resetn,
  input wire din,
  output reg dout
);
  reg stage1;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // ucs_sync2

// ### core/ucs_ctrl.v
// USB device control, configuration and last-transfer status registers
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/10ps
`include "ucs_regs.vh"

// Functional notes
// - Pointer reset returns banks to even
// - Live SE0 flag reads bus state
// - SETUP token sets packet freeze flag
// - Software clears freeze, processing resumes
// - Module enable runs the engine clock and arms the SETUP freeze; pull-ups do not depend on it
// - Resume control drives resume signalling
// - Suspend stops the engine clock
// - Eye test control drives test output
// - Pull-up on D+ or D- by speed
// - Speed select sets edge rates
// - Two-bit field selects ping-pong mode
// - Reserved config bits read zero
// - Status bits 6:3 give endpoint number
// - Direction bit one for IN
// - Odd bank bit reports last bank
// - Unimplemented bits read zero, ignore writes
// - Clearing done flag advances status queue
module ucs_ctrl (
  input wire core_clk,
  input wire resetn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire dp_in,
  input wire dm_in,
  input wire setup_token,
  input wire trn_push,
  input wire [3:0] trn_endpoint,
  input wire trn_in_dir,
  input wire trn_odd_bank,
  output wire queue_full,
  output reg module_enable,
  output reg packet_processing_freeze,
  output reg resume_drive,
  output reg low_power_suspend,
  output reg engine_clk_run,
  output reg ping_pong_pointer_reset,
  output reg eye_test_enable,
  output reg full_speed_select,
  output reg pullup_dp,
  output reg pullup_dm,
  output reg [1:0] buffer_alternation_cfg,
  output reg [15:0] odd_bank_capable
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  localparam QD = `UCS_QUEUE_DEPTH;

  reg pullup_enable;
  reg [6:0] qdata [0:QD-1];
  reg [1:0] rd_ptr;
  reg [1:0] wr_ptr;
  reg [2:0] count;
  reg trn_done;
  reg ack;
  wire se0;
  wire dp_s;
  wire dm_s;

  // ----------------------------------------------------------------
  // Bus pin sampling
  // ----------------------------------------------------------------
  ucs_sync2 u_sync_dp (
    .core_clk(core_clk),
    .resetn(resetn),
    .din(dp_in),
    .dout(dp_s)
  );

  ucs_sync2 u_sync_dm (
    .core_clk(core_clk),
    .resetn(resetn),
    .din(dm_in),
    .dout(dm_s)
  );

  // live SE0 detect
  // Lines sit at SE0 while detached, so the cleared synchronisers match the idle bus
  assign se0 = ~dp_s & ~dm_s;

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle for every access
  // ----------------------------------------------------------------
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  wire wr_go = avs_write & ack;
  wire rd_go = avs_read & ~ack;
  wire be0 = avs_byteenable[0];

  // Writes land on the second edge of a request, reads are captured on the first
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  wire ctl_wr = wr_go & be0 & (avs_address == `UCS_ADDR_CONTROL);
  wire cfg_wr = wr_go & be0 & (avs_address == `UCS_ADDR_CONFIG);
  wire trn_wr = wr_go & be0 & (avs_address == `UCS_ADDR_TRN);
  wire trn_clear = trn_wr & ~avs_writedata[`UCS_TRN_DONE] & trn_done;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ping_pong_pointer_reset <= 1'b0;
      packet_processing_freeze <= 1'b0;
      module_enable <= 1'b0;
      resume_drive <= 1'b0;
      low_power_suspend <= 1'b0;
    end else begin
      if (ctl_wr) begin
        ping_pong_pointer_reset <= avs_writedata[`UCS_CTL_PP_RESET];
        module_enable <= avs_writedata[`UCS_CTL_ENABLE];
        resume_drive <= avs_writedata[`UCS_CTL_RESUME];
        low_power_suspend <= avs_writedata[`UCS_CTL_SUSPEND];
      end
      if (setup_token & module_enable)
        packet_processing_freeze <= 1'b1;
      else if (ctl_wr & ~avs_writedata[`UCS_CTL_FREEZE])
        packet_processing_freeze <= 1'b0;
    end
  end

  // engine clock gate request, registered to avoid glitches
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      engine_clk_run <= 1'b0;
    end else begin
      engine_clk_run <= module_enable & ~low_power_suspend;
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      eye_test_enable <= 1'b0;
      pullup_enable <= 1'b0;
      full_speed_select <= 1'b0;
      buffer_alternation_cfg <= `UCS_PPB_NONE;
    end else if (cfg_wr) begin
      eye_test_enable <= avs_writedata[`UCS_CFG_EYE];
      // software keeps these stable while enabled; not blocked here
      pullup_enable <= avs_writedata[`UCS_CFG_PULLUP];
      full_speed_select <= avs_writedata[`UCS_CFG_FULL_SPEED];
      buffer_alternation_cfg <= avs_writedata[`UCS_CFG_PPB_LO+1:`UCS_CFG_PPB_LO];
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pullup_dp <= 1'b0;
      pullup_dm <= 1'b0;
    end else begin
      pullup_dp <= pullup_enable & full_speed_select;
      pullup_dm <= pullup_enable & ~full_speed_select;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      odd_bank_capable <= 16'h0000;
    end else begin
      case (buffer_alternation_cfg)
        `UCS_PPB_EP0_OUT: odd_bank_capable <= 16'h0001;
        `UCS_PPB_ALL: odd_bank_capable <= 16'hFFFF;
        `UCS_PPB_EP1_15: odd_bank_capable <= 16'hFFFE;
        default: odd_bank_capable <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transaction status queue
  // ----------------------------------------------------------------
  assign queue_full = (count == QD);
  // A push that meets a full queue is dropped; the engine must hold off until a pop
  wire push = trn_push & ~queue_full;
  wire pop = trn_clear & (count != 3'd0);
  reg [2:0] next_count;
  reg next_trn_done;

  always @(posedge core_clk) begin
    if (push)
      qdata[wr_ptr] <= {trn_endpoint, trn_in_dir, trn_odd_bank, 1'b0};
  end

  // Occupancy after this cycle; a push and a pop together leave it unchanged
  always @* begin
    next_count = count;
    next_trn_done = (count != 3'd0);
    case ({push, pop})
      2'b10: begin
        next_count = count + 3'd1;
        next_trn_done = 1'b1;
      end
      2'b01: begin
        next_count = count - 3'd1;
        // Flag follows whether an entry remains after the pop
        next_trn_done = (count > 3'd1);
      end
      2'b11: begin
        next_count = count;
        next_trn_done = 1'b1;
      end
      default: begin
        next_count = count;
        next_trn_done = (count != 3'd0);
      end
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ptr <= 2'd0;
      wr_ptr <= 2'd0;
      count <= 3'd0;
      trn_done <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 2'd1;
      if (pop)
        rd_ptr <= rd_ptr + 2'd1;
      count <= next_count;
      trn_done <= next_trn_done;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [6:0] head = (count != 3'd0) ? qdata[rd_ptr] : 7'd0;
  wire [7:0] ctl_word;
  wire [7:0] cfg_word;
  wire [7:0] stat_word;
  wire [7:0] trn_word;
  reg [31:0] next_readdata;

  assign ctl_word = {1'b0, ping_pong_pointer_reset, se0, packet_processing_freeze, module_enable,
    resume_drive, low_power_suspend, 1'b0};
  assign cfg_word = {eye_test_enable, 2'b00, pullup_enable, 1'b0, full_speed_select, buffer_alternation_cfg};
  assign stat_word = {1'b0, head};
  assign trn_word = {7'd0, trn_done};

  // Every register is one byte wide, so the upper lanes always read zero
  always @* begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `UCS_ADDR_CONTROL: next_readdata = {24'd0, ctl_word};
      `UCS_ADDR_CONFIG: next_readdata = {24'd0, cfg_word};
      `UCS_ADDR_STATUS: next_readdata = {24'd0, stat_word};
      `UCS_ADDR_TRN: next_readdata = {24'd0, trn_word};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Captured in the wait cycle so the word stands at the edge where waitrequest drops
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule // ucs_ctrl

// ### tb/ucs_host_model.sv
// Host side of the D+/D- lines: pull-downs, bus reset drive, device pull-ups
`timescale 1ns/10ps
module ucs_host_model (
  input wire se0_req,
  input wire pullup_dp,
  input wire pullup_dm,
  output wire dp_in,
  output wire dm_in
);
  // Host pull-downs win on a released line, so a detached device reads as SE0
  assign dp_in = pullup_dp & ~se0_req;
  assign dm_in = pullup_dm & ~se0_req;
endmodule // ucs_host_model

// ### tb/ucs_ctrl_checker.sv
// Port assertions for the USB control/config/status block
`timescale 1ns/10ps
module ucs_ctrl_checker (
  input wire core_clk,
  input wire resetn,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire setup_token,
  input wire module_enable,
  input wire packet_processing_freeze,
  input wire low_power_suspend,
  input wire engine_clk_run,
  input wire full_speed_select,
  input wire pullup_dp,
  input wire pullup_dm,
  input wire [1:0] buffer_alternation_cfg,
  input wire [15:0] odd_bank_capable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  AST_HIGH_ZERO: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_PULL_DP: assert property (pullup_dp |-> $past(full_speed_select) && !pullup_dm)
    else $error("D+ pull-up without full speed");
  AST_PULL_DM: assert property (pullup_dm |-> !$past(full_speed_select))
    else $error("D- pull-up with full speed");
  AST_ENGINE_CLK: assert property (engine_clk_run == $past(module_enable && !low_power_suspend))
    else $error("engine clock wrong for suspend");
  AST_ODD_BANKS: assert property (odd_bank_capable == ($past(buffer_alternation_cfg) == 2'b00 ? 16'h0 :
    $past(buffer_alternation_cfg) == 2'b01 ? 16'h1 : {15'h7FFF, !$past(buffer_alternation_cfg[0])}))
    else $error("odd bank map wrong");
  AST_FREEZE_SET: assert property (setup_token && module_enable |=> packet_processing_freeze)
    else $error("SETUP did not freeze");
  AST_FREEZE_HOLD: assert property (packet_processing_freeze && !avs_write |=> packet_processing_freeze)
    else $error("freeze dropped without write");
  COV_SETUP: cover property (setup_token && module_enable);
  COV_READ: cover property (avs_read && !avs_waitrequest);
  COV_PULL: cover property (pullup_dp);
endmodule // ucs_ctrl_checker
bind ucs_ctrl ucs_ctrl_checker i_ucs_ctrl_checker (.*);

// ### tb/ucs_ctrl_bench.sv
// Self-checking bench for the USB control/config/status registers
`timescale 1ns/10ps
module ucs_ctrl_bench;
  logic core_clk = 0, resetn = 0, rd = 0, wr = 0, se0 = 0, stok = 0, push = 0, pdir = 0, podd = 0;
  logic [3:0] adr = 0, pep = 0, be = 4'hF;
  logic [31:0] wdat = 0, rdat, seed = 32'h0000_fd8a;
  logic wreq, dp, dm, qf, en, frz, res, sus, eclk, pprst, eye, fs, pdp, pdm;
  logic [1:0] ppb;
  logic [15:0] obc;
  logic [7:0] d;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int num_checks = 0;
  ucs_ctrl i_ucs_ctrl (.core_clk(core_clk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .dp_in(dp), .dm_in(dm), .setup_token(stok), .trn_push(push),
    .trn_endpoint(pep), .trn_in_dir(pdir), .trn_odd_bank(podd), .queue_full(qf), .module_enable(en),
    .packet_processing_freeze(frz), .resume_drive(res), .low_power_suspend(sus), .engine_clk_run(eclk),
    .ping_pong_pointer_reset(pprst), .eye_test_enable(eye), .full_speed_select(fs), .pullup_dp(pdp),
    .pullup_dm(pdm), .buffer_alternation_cfg(ppb), .odd_bank_capable(obc));
  ucs_host_model i_ucs_host_model (.se0_req(se0), .pullup_dp(pdp), .pullup_dm(pdm), .dp_in(dp), .dm_in(dm));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] ob(input logic [1:0] p);
    return p == 2'b00 ? 16'h0 : p == 2'b01 ? 16'h1 : p == 2'b10 ? 16'hFFFF : 16'hFFFE;
  endfunction
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: pin level %h expected %h", $time, got, exp);
    end
  endtask
  // A read queues its expected word; the monitor pops it when the answer lands
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] v);
    @(posedge core_clk);
    adr <= a;
    wdat <= v;
    wr <= w;
    rd <= !w;
    if (!w) exp_q.push_back(v);
    @(posedge core_clk);
    while (wreq) @(posedge core_clk);
    wr <= 0;
    rd <= 0;
  endtask
  task automatic tpush(input logic [3:0] ep, input logic dir, input logic odd);
    @(posedge core_clk);
    pep <= ep;
    pdir <= dir;
    podd <= odd;
    push <= 1;
    @(posedge core_clk);
    push <= 0;
  endtask
  always @(posedge core_clk) begin
    if (rd && !wreq) chk(rdat, exp_q.pop_front());
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  // ----------------
  // Stimulus
  // ----------------
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1;
    // Detached: host pull-downs hold both lines low, so the live SE0 bit reads one
    bus(4'h0, 0, 32'h20);
    bus(4'h4, 0, 32'h0);
    bus(4'h8, 0, 32'h0);
    bus(4'h2, 1, 32'hFF);
    bus(4'h2, 0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      d = {seed[7:2], 2'(i)};
      bus(4'h4, 1, {24'h0, d});
      bus(4'h4, 0, {24'h0, d & 8'h97});
      #1;
      chk_pin({eye, fs, ppb}, {d[7], d[2], d[1:0]});
      chk_pin({pdp, pdm, obc}, {d[4] & d[2], d[4] & ~d[2], ob(d[1:0])});
    end
    // Pull-up and speed are fixed before the module is enabled
    bus(4'h4, 1, 32'h14);
    bus(4'h0, 1, 32'hFF);
    bus(4'h0, 0, 32'h4E);
    #1;
    chk_pin({en, res, sus, pprst, eclk, frz}, 6'b111100);
    @(posedge core_clk);
    se0 <= 1;
    repeat (4) @(posedge core_clk);
    bus(4'h0, 0, 32'h6E);
    se0 <= 0;
    stok <= 1;
    @(posedge core_clk);
    stok <= 0;
    repeat (4) @(posedge core_clk);
    bus(4'h0, 0, 32'h5E);
    bus(4'h0, 1, 32'h4E);
    bus(4'h0, 0, 32'h4E);
    bus(4'h0, 1, 32'h08);
    bus(4'h0, 0, 32'h08);
    #1;
    chk_pin({eclk, pprst, res}, 3'b100);
    // A write without lane 0 must leave the control byte alone
    @(posedge core_clk);
    be <= 4'hE;
    bus(4'h0, 1, 32'h00);
    be <= 4'hF;
    bus(4'h0, 0, 32'h08);
    for (int i = 0; i < 5; i++) tpush(4'(15 - i * 5), i[0], i[1]);
    #1;
    chk_pin(qf, 1);
    for (int i = 0; i < 4; i++) begin
      bus(4'h8, 0, {25'h0, 4'(15 - i * 5), i[0], i[1], 1'b0});
      bus(4'hC, 0, 32'h1);
      bus(4'hC, 1, 32'h0);
    end
    bus(4'h8, 0, 32'h0);
    bus(4'hC, 0, 32'h0);
    summarize();
  end
endmodule // ucs_ctrl_bench
